/* hdl/harvest_regs_pkg.sv */
package harvest_regs_pkg;

	// ************************************************************
	// Register offsets and reset values
	// ************************************************************
	localparam logic [7:0]  OFF_OPEN_CIRCUIT_VOLTAGE  = 8'h09;
	localparam logic [7:0]  OFF_HARVEST_COUNT_HIGH    = 8'h0A;
	localparam logic [7:0]  OFF_HARVEST_COUNT_LOW     = 8'h0B;
	localparam logic [7:0]  OFF_SLEEP_COUNT_THRESHOLD = 8'h0C;
	localparam logic [7:0]  RST_OPEN_CIRCUIT_VOLTAGE  = 8'h1D;
	localparam logic [7:0]  RST_SLEEP_COUNT_THRESHOLD = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED             = 8'h00;

	// ************************************************************
	// Pulse counter
	// ************************************************************
	localparam int          COUNT_WIDTH               = 16;
	localparam logic [15:0] COUNT_RESET               = 16'h0000;
	localparam logic [15:0] COUNT_MAX                 = 16'hFFFF;

	// ************************************************************
	// Automatic measurement period codes and lengths in Tmeas units
	// ************************************************************
	localparam logic [1:0]  PERIOD_CODE_64            = 2'h0;
	localparam logic [1:0]  PERIOD_CODE_128           = 2'h1;
	localparam logic [1:0]  PERIOD_CODE_256           = 2'h2;
	localparam logic [1:0]  PERIOD_CODE_OFF           = 2'h3;
	localparam logic [8:0]  PERIOD_LEN_64             = 9'h040;
	localparam logic [8:0]  PERIOD_LEN_128            = 9'h080;
	localparam logic [8:0]  PERIOD_LEN_256            = 9'h100;
	localparam logic [8:0]  PERIOD_CNT_RESET          = 9'h000;

	// ************************************************************
	// Serial target
	// ************************************************************
	// Arbitrary target address; not tied to any real part.
	localparam logic [6:0]  I2C_DEV_ADDR              = 7'h2A;
	localparam logic [3:0]  I2C_BITS_PER_BYTE         = 4'h8;

endpackage

/* hdl/reg_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Internal register access between the serial target and the register bank.
interface reg_bus_if;
	logic       wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport target (
		output wr_stb,
		output addr,
		output wdata,
		input  rdata
	);

	modport regs (
		input  wr_stb,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface

`default_nettype wire

/* hdl/i2c_reg_target.sv */
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_target #(
	parameter logic [6:0] DEV_ADDR = harvest_regs_pkg::I2C_DEV_ADDR
) (
	// Clock, reset and enable.
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// Serial pins; data is open drain.
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_n_o,
	// Register side.
	reg_bus_if.target bus
);

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WDATA    = 3'b011,
		ST_WACK     = 3'b100,
		ST_RDATA    = 3'b101,
		ST_RACK     = 3'b110
	} tgt_state_e;

	tgt_state_e state_reg;
	logic       scl_meta_reg, scl_sync_reg, scl_prev_reg;
	logic       sda_meta_reg, sda_sync_reg, sda_prev_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic       rw_reg;
	logic       first_reg;
	logic       nack_reg;
	logic       scl_rise, scl_fall, start_cond, stop_cond;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Only the second stage and its delayed copy feed the edge logic.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else if (ce_i) begin
			scl_meta_reg <= scl_i;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_i;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	// Bus conditions seen on the synchronised lines.
	assign scl_rise   = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall   = ~scl_sync_reg & scl_prev_reg;
	assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg
		& ~sda_sync_reg;
	assign stop_cond  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg
		& sda_sync_reg;

	// ************************************************************
	// Protocol engine
	// ************************************************************
	// Bits are sampled on the clock rise and driven after the fall, so
	// the data line never moves while the clock is high.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			rw_reg      <= 1'b0;
			first_reg   <= 1'b0;
			nack_reg    <= 1'b0;
			sda_o       <= 1'b0;
			sda_oe_n_o  <= 1'b1;
			bus.wr_stb  <= 1'b0;
			bus.addr    <= 8'h00;
			bus.wdata   <= 8'h00;
		end else if (ce_i) begin
			bus.wr_stb <= 1'b0;
			if (start_cond) begin
				state_reg   <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_n_o  <= 1'b1;
			end else if (stop_cond) begin
				state_reg  <= ST_IDLE;
				sda_oe_n_o <= 1'b1;
			end else if (scl_rise) begin
				if (state_reg == ST_ADDR || state_reg == ST_WDATA) begin
					shift_reg   <= {shift_reg[6:0], sda_sync_reg};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (state_reg == ST_RDATA) begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (state_reg == ST_RACK) begin
					nack_reg <= sda_sync_reg;
				end
			end else if (scl_fall) begin
				case (state_reg)
					ST_ADDR: begin
						if (bit_cnt_reg == harvest_regs_pkg::I2C_BITS_PER_BYTE) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								rw_reg     <= shift_reg[0];
								sda_oe_n_o <= 1'b0;
								state_reg  <= ST_ADDR_ACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg) begin
							tx_reg     <= bus.rdata;
							sda_oe_n_o <= bus.rdata[7];
							state_reg  <= ST_RDATA;
						end else begin
							first_reg  <= 1'b1;
							sda_oe_n_o <= 1'b1;
							state_reg  <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (bit_cnt_reg == harvest_regs_pkg::I2C_BITS_PER_BYTE) begin
							sda_oe_n_o <= 1'b0;
							state_reg  <= ST_WACK;
							if (first_reg) begin
								bus.addr <= shift_reg;
							end else begin
								bus.wr_stb <= 1'b1;
								bus.wdata  <= shift_reg;
							end
						end
					end
					ST_WACK: begin
						// The pointer byte itself must not step the pointer.
						if (!first_reg) begin
							bus.addr <= bus.addr + 8'h01;
						end
						first_reg   <= 1'b0;
						sda_oe_n_o  <= 1'b1;
						bit_cnt_reg <= 4'h0;
						state_reg   <= ST_WDATA;
					end
					ST_RDATA: begin
						if (bit_cnt_reg == harvest_regs_pkg::I2C_BITS_PER_BYTE) begin
							sda_oe_n_o <= 1'b1;
							bus.addr   <= bus.addr + 8'h01;
							state_reg  <= ST_RACK;
						end else begin
							sda_oe_n_o <= tx_reg[3'h7 - bit_cnt_reg[2:0]];
						end
					end
					ST_RACK: begin
						bit_cnt_reg <= 4'h0;
						if (nack_reg) begin
							state_reg <= ST_IDLE;
						end else begin
							tx_reg     <= bus.rdata;
							sda_oe_n_o <= bus.rdata[7];
							state_reg  <= ST_RDATA;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* hdl/harvest_count_and_sleep_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Latest open-circuit voltage readable any time.
// RULE2: Host write overrides measured voltage value.
// RULE3: Voltage update below default halts boost, sleeps.
// RULE4: Next measurement or higher write ends sleep.
// RULE5: Host avoids voltage write during forced measure.
// RULE6: Upper pulse count byte in read-only register.
// RULE7: Lower pulse count byte in read-only register.
// RULE8: Count meaningful only with rail above wake.
// RULE9: Pulse counter saturates at all ones.
// RULE10: Pulse counter frozen while in sleep.
// RULE11: Threshold compare forces sleep until next measurement.
// RULE12: Zero threshold disables count-based sleep.
// RULE13: Period code selects 64/128/256 or off.
// RULE14: Sleep when count below nonzero threshold.

module harvest_count_and_sleep_regs #(
	parameter logic [6:0] DEV_ADDR = harvest_regs_pkg::I2C_DEV_ADDR
) (
	// Clock, reset and enable.
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	// Serial register access.
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	// Measurement engine, same clock.
	input  wire logic       tmeas_tick_i,
	input  wire logic [1:0] period_code_i,
	input  wire logic       forced_open_circuit_request_i,
	input  wire logic       meas_done_i,
	input  wire logic [7:0] meas_value_i,
	output logic            meas_start_o,
	// Analog pins.
	input  wire logic       switch_node_pulse_i,
	input  wire logic       output_rail_i,
	// Status.
	output logic            sleep_o,
	output logic            boost_halt_o,
	output logic            count_valid_o
);

	reg_bus_if bus ();

	logic [7:0]  voc_reg;
	logic [7:0]  threshold_reg;
	logic [15:0] harvest_pulse_count_reg;
	logic        low_voltage_sleep_reg;
	logic        count_sleep_reg;
	logic [8:0]  period_cnt_reg;
	logic        pulse_meta_reg, pulse_sync_reg, pulse_prev_reg;
	logic        rail_meta_reg, rail_sync_reg;
	logic        voc_wr, thr_wr, voc_update, sleeping, pulse_edge;
	logic        period_fire;
	logic [7:0]  voc_next;

	// Address compare shared by both writable registers.
	function automatic logic addr_hit(input logic [7:0] a,
			input logic [7:0] off);
		return a == off;
	endfunction

	// Automatic period length in measurement times for a code.
	function automatic logic [8:0] period_len(input logic [1:0] code);
		case (code)
			harvest_regs_pkg::PERIOD_CODE_64:  period_len =
				harvest_regs_pkg::PERIOD_LEN_64;
			harvest_regs_pkg::PERIOD_CODE_128: period_len =
				harvest_regs_pkg::PERIOD_LEN_128;
			default:                           period_len =
				harvest_regs_pkg::PERIOD_LEN_256;
		endcase
	endfunction

	// ************************************************************
	// Serial target
	// ************************************************************
	i2c_reg_target #(
		.DEV_ADDR   (DEV_ADDR)
	) u_target (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_o      (sda_o),
		.sda_oe_n_o (sda_oe_n_o),
		.bus        (bus.target)
	);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// The pulse train and the wake comparator are asynchronous.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pulse_meta_reg <= 1'b0;
			pulse_sync_reg <= 1'b0;
			pulse_prev_reg <= 1'b0;
			rail_meta_reg  <= 1'b0;
			rail_sync_reg  <= 1'b0;
		end else if (ce_i) begin
			pulse_meta_reg <= switch_node_pulse_i;
			pulse_sync_reg <= pulse_meta_reg;
			pulse_prev_reg <= pulse_sync_reg;
			rail_meta_reg  <= output_rail_i;
			rail_sync_reg  <= rail_meta_reg;
		end
	end

	// Decoded strobes and shared terms.
	assign voc_wr     = bus.wr_stb
		& addr_hit(bus.addr, harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE);
	assign thr_wr     = bus.wr_stb
		& addr_hit(bus.addr, harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD);
	assign voc_update = voc_wr | meas_done_i;
	// A host write landing with a result wins: it is the override.
	assign voc_next   = voc_wr ? bus.wdata : meas_value_i; // [RULE2]
	assign sleeping   = low_voltage_sleep_reg | count_sleep_reg;
	assign pulse_edge = pulse_sync_reg & ~pulse_prev_reg;

	// ************************************************************
	// Voltage register and low-voltage sleep
	// ************************************************************
	// Write while a forced measurement runs is taken; the later result
	// replaces it, which is why the host should not do that. [RULE5]
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			voc_reg <= harvest_regs_pkg::RST_OPEN_CIRCUIT_VOLTAGE;
		end else if (ce_i && voc_update) begin
			voc_reg <= voc_next; // [RULE1] [RULE2]
		end
	end

	// Every update re-judges the level, so a new result or a write at
	// or above the default releases the sleep.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			low_voltage_sleep_reg <= 1'b0;
		end else if (ce_i && voc_update) begin
			low_voltage_sleep_reg <= voc_next
				< harvest_regs_pkg::RST_OPEN_CIRCUIT_VOLTAGE; // [RULE3] [RULE4]
		end
	end

	// ************************************************************
	// Threshold register and count-based sleep
	// ************************************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			threshold_reg <= harvest_regs_pkg::RST_SLEEP_COUNT_THRESHOLD;
		end else if (ce_i && thr_wr) begin
			threshold_reg <= bus.wdata;
		end
	end

	// Judged once per measurement time so a freshly cleared count is
	// not punished before it had a chance to grow.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			count_sleep_reg <= 1'b0;
		end else if (ce_i) begin
			if (meas_done_i) begin
				count_sleep_reg <= 1'b0; // [RULE11]
			end else if (tmeas_tick_i && !sleeping
					&& threshold_reg != harvest_regs_pkg::RST_SLEEP_COUNT_THRESHOLD
					&& harvest_pulse_count_reg < {8'h00, threshold_reg}) begin
				count_sleep_reg <= 1'b1; // [RULE11] [RULE12] [RULE14]
			end
		end
	end

	// ************************************************************
	// Pulse counter
	// ************************************************************
	// Restarts with each measurement; holds at all ones; frozen in sleep.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			harvest_pulse_count_reg <= harvest_regs_pkg::COUNT_RESET;
		end else if (ce_i) begin
			if (meas_done_i) begin
				harvest_pulse_count_reg <= harvest_regs_pkg::COUNT_RESET;
			end else if (pulse_edge && !sleeping // [RULE10]
					&& harvest_pulse_count_reg != harvest_regs_pkg::COUNT_MAX) begin
				harvest_pulse_count_reg <= harvest_pulse_count_reg
					+ 16'h0001; // [RULE9]
			end
		end
	end

	// ************************************************************
	// Automatic measurement scheduling
	// ************************************************************
	assign period_fire = tmeas_tick_i
		&& period_code_i != harvest_regs_pkg::PERIOD_CODE_OFF
		&& period_cnt_reg + 9'h001 >= period_len(period_code_i);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			period_cnt_reg <= harvest_regs_pkg::PERIOD_CNT_RESET;
		end else if (ce_i && tmeas_tick_i) begin
			if (period_code_i == harvest_regs_pkg::PERIOD_CODE_OFF
					|| period_fire) begin
				period_cnt_reg <= harvest_regs_pkg::PERIOD_CNT_RESET; // [RULE13]
			end else begin
				period_cnt_reg <= period_cnt_reg + 9'h001;
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			meas_start_o  <= 1'b0;
			sleep_o       <= 1'b0;
			boost_halt_o  <= 1'b0;
			count_valid_o <= 1'b0;
		end else if (ce_i) begin
			meas_start_o  <= period_fire
				| forced_open_circuit_request_i; // [RULE13]
			sleep_o       <= sleeping;
			boost_halt_o  <= sleeping; // [RULE3]
			count_valid_o <= rail_sync_reg; // [RULE8]
		end
	end

	// Read data; unmapped offsets return zero.
	always_comb begin
		case (bus.addr)
			harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE:
				bus.rdata = voc_reg; // [RULE1]
			harvest_regs_pkg::OFF_HARVEST_COUNT_HIGH:
				bus.rdata = harvest_pulse_count_reg[15:8]; // [RULE6]
			harvest_regs_pkg::OFF_HARVEST_COUNT_LOW:
				bus.rdata = harvest_pulse_count_reg[7:0]; // [RULE7]
			harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD:
				bus.rdata = threshold_reg;
			default:
				bus.rdata = harvest_regs_pkg::READ_UNMAPPED;
		endcase
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_voc_write_taken: assert property ( // [RULE2]
		ce_i && voc_wr |=> voc_reg == $past(bus.wdata))
		else $error("Host write did not reach the voltage register.");

	a_low_voc_sleep: assert property ( // [RULE3]
		ce_i && voc_update && voc_next < 8'h1D ##1 ce_i |=> boost_halt_o)
		else $error("Low voltage update did not halt the boost.");

	a_meas_wakes: assert property ( // [RULE4]
		ce_i && meas_done_i && !voc_wr && meas_value_i >= 8'h1D
		|=> !low_voltage_sleep_reg)
		else $error("Measurement at or above default kept the sleep.");

	a_count_high_read: assert property ( // [RULE6]
		bus.addr == 8'h0A |-> bus.rdata == harvest_pulse_count_reg[15:8])
		else $error("High count byte read is wrong.");

	a_count_low_read: assert property ( // [RULE7]
		bus.addr == 8'h0B |-> bus.rdata == harvest_pulse_count_reg[7:0])
		else $error("Low count byte read is wrong.");

	a_valid_follows_rail: assert property ( // [RULE8]
		ce_i && output_rail_i ##1 ce_i && output_rail_i ##1 ce_i
		|=> count_valid_o)
		else $error("Count valid did not follow the rail.");

	a_count_saturates: assert property ( // [RULE9]
		ce_i && harvest_pulse_count_reg == 16'hFFFF && !meas_done_i
		|=> harvest_pulse_count_reg == 16'hFFFF)
		else $error("Pulse counter wrapped past all ones.");

	a_count_frozen: assert property ( // [RULE10]
		sleeping && !meas_done_i |=> $stable(harvest_pulse_count_reg))
		else $error("Pulse counter moved during sleep.");

	a_count_sleep_set: assert property ( // [RULE11] [RULE14]
		ce_i && tmeas_tick_i && !sleeping && !meas_done_i
		&& threshold_reg != 8'h00
		&& harvest_pulse_count_reg < {8'h00, threshold_reg}
		|=> count_sleep_reg ##1 (sleep_o || !$past(ce_i)))
		else $error("Count below threshold did not force sleep.");

	a_zero_thr_off: assert property ( // [RULE12]
		threshold_reg == 8'h00 |=> !$rose(count_sleep_reg))
		else $error("Zero threshold still forced sleep.");

	a_period_off: assert property ( // [RULE13]
		ce_i && period_code_i == 2'h3 && !forced_open_circuit_request_i
		|=> !meas_start_o)
		else $error("Measurement started with automatic period off.");

endmodule

`default_nettype wire

/* bench/i2c_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Serial host on the far side of the register block.
// SCL idles high; SDA is open drain with a pull-up.
module i2c_host_model (
	// Clock, line level and forced-measurement busy flag.
	input  wire logic core_clk_i,
	input  wire logic sda_i,
	input  wire logic forced_busy_i,
	// Host drives.
	output logic      scl_o,
	output logic      sda_low_o
);
	// ************************************************************
	// Bit timing
	// ************************************************************
	// Lines idle released until the first frame.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Eight cycles a half bit keeps SCL high well past four.
	task automatic half();
		repeat (8) @(negedge core_clk_i);
	endtask

	// Also serves as repeated start, since SCL is low on entry then.
	task automatic start_cond();
		sda_low_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_low_o = 1'b1;
		half();
		scl_o = 1'b0;
		half();
	endtask

	task automatic stop_cond();
		sda_low_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_low_o = 1'b0;
		half();
	endtask

	// Data moves only a quarter bit after SCL falls, so it is never
	// seen changing while the synchronised SCL still reads high.
	task automatic clock_bit(input logic b, output logic r);
		sda_low_o = !b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_i;
		scl_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask

	// ************************************************************
	// Byte and register transfers
	// ************************************************************
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], r);
		end
		clock_bit(1'b1, r);
		ack = !r;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, r);
			d[i] = r;
		end
		clock_bit(last, r);
	endtask

	task automatic write_reg(input logic [7:0] off, input logic [7:0] d,
			output logic ok);
		logic a0, a1, a2;
		// No voltage write while a forced measurement is pending.
		while (forced_busy_i) @(negedge core_clk_i);
		start_cond();
		send_byte({harvest_regs_pkg::I2C_DEV_ADDR, 1'b0}, a0);
		send_byte(off, a1);
		send_byte(d, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [7:0] off, output logic [7:0] d,
			output logic ok);
		logic a0, a1, a2;
		start_cond();
		send_byte({harvest_regs_pkg::I2C_DEV_ADDR, 1'b0}, a0);
		send_byte(off, a1);
		start_cond();
		send_byte({harvest_regs_pkg::I2C_DEV_ADDR, 1'b1}, a2);
		recv_byte(1'b1, d);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule

`default_nettype wire

/* bench/harvest_count_and_sleep_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module harvest_count_and_sleep_regs_bench;
	// ************************************************************
	// Signals
	// ************************************************************
	logic       core_clk_i;
	logic       sys_rst_i;
	logic       scl;
	logic       host_low;
	wire logic  sda_line;
	logic       sda_o;
	logic       sda_oe_n_o;
	logic       tmeas_tick_i;
	logic [1:0] period_code_i;
	logic       forced_open_circuit_request_i;
	logic       meas_done_i;
	logic [7:0] meas_value_i;
	logic       meas_start_o;
	logic       switch_node_pulse_i;
	logic       output_rail_i;
	logic       ce_i = 1'b1;
	logic       sleep_o;
	logic       boost_halt_o;
	logic       count_valid_o;
	int         fail_count;
	int         tests_run;
	int         cycles;
	int         starts;

	// Open-drain line: either party pulls low, the pull-up wins otherwise.
	assign sda_line = host_low ? 1'b0 : (!sda_oe_n_o ? sda_o : 1'b1);

	harvest_count_and_sleep_regs i_dut (
		.core_clk_i                    (core_clk_i),
		.sys_rst_i                     (sys_rst_i),
		.ce_i                          (ce_i),
		.scl_i                         (scl),
		.sda_i                         (sda_line),
		.sda_o                         (sda_o),
		.sda_oe_n_o                    (sda_oe_n_o),
		.tmeas_tick_i                  (tmeas_tick_i),
		.period_code_i                 (period_code_i),
		.forced_open_circuit_request_i (forced_open_circuit_request_i),
		.meas_done_i                   (meas_done_i),
		.meas_value_i                  (meas_value_i),
		.meas_start_o                  (meas_start_o),
		.switch_node_pulse_i           (switch_node_pulse_i),
		.output_rail_i                 (output_rail_i),
		.sleep_o                       (sleep_o),
		.boost_halt_o                  (boost_halt_o),
		.count_valid_o                 (count_valid_o)
	);

	i2c_host_model i_host (
		.core_clk_i    (core_clk_i),
		.sda_i         (sda_line),
		.forced_busy_i (forced_open_circuit_request_i),
		.scl_o         (scl),
		.sda_low_o     (host_low)
	);

	// ************************************************************
	// Clock, timeout and measurement start counter
	// ************************************************************
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	// Ceiling sits well above the roughly 19000 cycles the run needs.
	always @(posedge core_clk_i) begin
		cycles++;
		if (meas_start_o === 1'b1) starts++;
		if (cycles == 60000) begin
			fail_count++;
			results();
		end
	end

	// ************************************************************
	// Compare and access tasks
	// ************************************************************
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic ok;
		i_host.write_reg(off, d, ok);
		check1(ok, 1'b1);
	endtask

	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		logic       ok;
		logic [7:0] d;
		i_host.read_reg(off, d, ok);
		check1(ok, 1'b1);
		check8(d, exp);
	endtask

	// Engine result pulse; three cycles let both sleep stages settle.
	task automatic meas(input logic [7:0] v);
		meas_done_i = 1'b1;
		meas_value_i = v;
		@(negedge core_clk_i);
		meas_done_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			tmeas_tick_i = 1'b1;
			@(negedge core_clk_i);
			tmeas_tick_i = 1'b0;
			repeat (3) @(negedge core_clk_i);
		end
	endtask

	// Pulses are slow enough for the synchroniser to see each.
	task automatic pulses(input int n);
		repeat (n) begin
			switch_node_pulse_i = 1'b1;
			repeat (2) @(negedge core_clk_i);
			switch_node_pulse_i = 1'b0;
			repeat (2) @(negedge core_clk_i);
		end
		repeat (6) @(negedge core_clk_i);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		starts = 0;
		sys_rst_i = 1'b1;
		tmeas_tick_i = 1'b0;
		period_code_i = harvest_regs_pkg::PERIOD_CODE_OFF;
		forced_open_circuit_request_i = 1'b0;
		meas_done_i = 1'b0;
		meas_value_i = 8'h00;
		switch_node_pulse_i = 1'b0;
		output_rail_i = 1'b0;
		repeat (12) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		check1(sleep_o, 1'b0);
		rd(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h1D);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_HIGH, 8'h00);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_LOW, 8'h00);
		rd(harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD, 8'h00);
		rd(8'h20, harvest_regs_pkg::READ_UNMAPPED);
		check1(count_valid_o, 1'b0);
		output_rail_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		check1(count_valid_o, 1'b1);
		// Host override just below the default value.
		wr(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h1C);
		rd(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h1C);
		check1(sleep_o, 1'b1);
		check1(boost_halt_o, 1'b1);
		pulses(4);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_LOW, 8'h00);
		wr(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h1D);
		check1(sleep_o, 1'b0);
		check1(boost_halt_o, 1'b0);
		wr(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h10);
		meas(8'h30);
		check1(sleep_o, 1'b0);
		rd(harvest_regs_pkg::OFF_OPEN_CIRCUIT_VOLTAGE, 8'h30);
		meas(8'h1C);
		check1(sleep_o, 1'b1);
		meas(8'h30);
		// Counter bytes, and writes to them that must be dropped.
		pulses(261);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_HIGH, 8'h01);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_LOW, 8'h05);
		ce_i = 1'b0;
		pulses(2);
		ce_i = 1'b1;
		wr(harvest_regs_pkg::OFF_HARVEST_COUNT_HIGH, 8'hFF);
		wr(harvest_regs_pkg::OFF_HARVEST_COUNT_LOW, 8'hFF);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_HIGH, 8'h01);
		rd(harvest_regs_pkg::OFF_HARVEST_COUNT_LOW, 8'h05);
		// Count-based sleep below, at and without a threshold.
		meas(8'h30);
		pulses(3);
		wr(harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD, 8'h10);
		rd(harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD, 8'h10);
		tick(1);
		check1(sleep_o, 1'b1);
		meas(8'h30);
		check1(sleep_o, 1'b0);
		pulses(16);
		tick(1);
		check1(sleep_o, 1'b0);
		wr(harvest_regs_pkg::OFF_SLEEP_COUNT_THRESHOLD, 8'h00);
		meas(8'h30);
		tick(1);
		check1(sleep_o, 1'b0);
		// Automatic period lengths: no start one tick short, then one.
		for (int k = 0; k < 3; k++) begin
			period_code_i = harvest_regs_pkg::PERIOD_CODE_OFF;
			@(negedge core_clk_i);
			period_code_i = 2'(k);
			starts = 0;
			tick((64 << k) - 1);
			check8(8'(starts), 8'h00);
			tick(1);
			check8(8'(starts), 8'h01);
		end
		period_code_i = harvest_regs_pkg::PERIOD_CODE_OFF;
		@(negedge core_clk_i);
		starts = 0;
		tick(300);
		check8(8'(starts), 8'h00);
		forced_open_circuit_request_i = 1'b1;
		@(negedge core_clk_i);
		forced_open_circuit_request_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
		check8(8'(starts), 8'h01);
		results();
	end
endmodule

`default_nettype wire
